// File: rtl/cell_aux_diag_current_config.v
/*
 Register pair for the cell open check mode and the diagnostic test
 current source enables of the cell, auxiliary and sense amplifier inputs.
 Assumes a plain register port: one-cycle strobes, read data a cycle later.
 Level, direction, GPIO and I2C modes come from other blocks as inputs.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cell_aux_diag_current_map.vh"

// Operation
// (RULE1) Bit 15 selects normal or open check
// (RULE2) Normal: enabled channels, standard thresholds, both sequences
// (RULE3) Open check: enabled and polarity clear only
// (RULE4) Open check: low side comparator, open thresholds
// (RULE5) Software: pull-downs on, comparator-only scan
// (RULE6) Software: pair with discharge or grounded aux
// (RULE7) Fifteen bits enable cell current sources
// (RULE8) Bits 5, 4 drive sense amp sources
// (RULE9) Sense amp sources pull-up only
// (RULE10) Bits 3 to 0 drive aux sources
// (RULE11) GPIO mode masks aux enable, readback kept
// (RULE12) I2C mode masks aux bits 1,0
// (RULE13) Unused bits read zero, ignore writes
module cell_aux_diag_current_config (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWriteData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [15:0] regReadData,
  input  wire [14:0] cellMeasureEnable,
  input  wire [14:0] cellPolaritySelect,
  input  wire [5:0]  auxGpioEnable,
  input  wire        auxI2cEnable,
  input  wire [9:0]  testCurrentLevelIn,
  input  wire        testCurrentDirectionIn,
  output wire        cellOpenCheckSelect,
  output wire [14:0] cellChannelMeasure,
  output wire        comparatorLowSideOnly,
  output wire        openThresholdSetSelect,
  output wire        adcSequenceEnable,
  output reg  [14:0] cellSourceOn,
  output reg  [3:0]  auxSourceOn,
  output reg         sensePosSourceOn,
  output reg         senseNegSourceOn,
  output reg  [9:0]  testCurrentLevel,
  output reg  [3:0]  auxSourcePullUp,
  output reg         senseSourcePullUp
);

  reg         openCheck;
  reg  [14:0] cellTestCurrentEnable;
  reg  [5:0]  auxTestCurrentEnable;
  wire [5:0]  auxEffective;
  wire [15:0] cellWord;
  wire [15:0] auxWord;
  wire [15:0] auxResetWord;

  // Aux reset word; only its enable field is stored
  assign auxResetWord = `AUX_TEST_CURRENT_CONFIG_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clk) begin
    if (!rst_n) begin
      {openCheck, cellTestCurrentEnable} <= `CELL_TEST_CURRENT_CONFIG_RST;
      auxTestCurrentEnable  <= auxResetWord[`AUX_TEST_EN_MSB:`AUX_TEST_EN_LSB];
    end else if (regWrite) begin
      if (regAddr == `CELL_TEST_CURRENT_CONFIG_ADDR) begin
        openCheck             <= regWriteData[`CELL_OPEN_CHECK_SELECT_BIT]; // [RULE1]
        cellTestCurrentEnable <= regWriteData[`CELL_TEST_EN_MSB:`CELL_TEST_EN_LSB];
      end else if (regAddr == `AUX_TEST_CURRENT_CONFIG_ADDR) begin
        auxTestCurrentEnable  <= regWriteData[`AUX_TEST_EN_MSB:`AUX_TEST_EN_LSB]; // [RULE13]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback shows the stored value, not the gated one
  assign cellWord = {openCheck, cellTestCurrentEnable};
  assign auxWord  = {10'h000, auxTestCurrentEnable}; // [RULE11] [RULE12] [RULE13]

  always @(posedge clk) begin
    if (!rst_n) begin
      regReadData <= 16'h0000;
    end else if (regRead) begin
      if (regAddr == `CELL_TEST_CURRENT_CONFIG_ADDR) begin
        regReadData <= cellWord;
      end else if (regAddr == `AUX_TEST_CURRENT_CONFIG_ADDR) begin
        regReadData <= auxWord;
      end else begin
        regReadData <= 16'h0000; // Unmapped addresses read zero
      end
    end else begin
      regReadData <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating of aux enables by GPIO and I2C modes
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : gAux
      if (k < 2) begin : gI2c
        assign auxEffective[k] = auxTestCurrentEnable[k] & ~auxGpioEnable[k]
                               & ~auxI2cEnable; // [RULE11] [RULE12]
      end else begin : gGpio
        assign auxEffective[k] = auxTestCurrentEnable[k] & ~auxGpioEnable[k]; // [RULE11]
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Current source drive
  always @(posedge clk) begin
    if (!rst_n) begin
      cellSourceOn      <= 15'h0000;
      auxSourceOn       <= 4'h0;
      sensePosSourceOn  <= 1'b0;
      senseNegSourceOn  <= 1'b0;
      testCurrentLevel  <= 10'h000;
      auxSourcePullUp   <= 4'h0;
      senseSourcePullUp <= 1'b1;
    end else begin
      cellSourceOn      <= cellTestCurrentEnable;                   // [RULE7]
      testCurrentLevel  <= testCurrentLevelIn;                      // [RULE7] [RULE10]
      auxSourceOn       <= auxEffective[3:0];                       // [RULE10]
      auxSourcePullUp   <= {4{testCurrentDirectionIn}};             // [RULE10]
      sensePosSourceOn  <= auxEffective[`SENSE_POS_BIT];            // [RULE8]
      senseNegSourceOn  <= auxEffective[`SENSE_NEG_BIT];            // [RULE8]
      senseSourcePullUp <= `DIRECTION_PULL_UP;                      // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel selection and threshold control
  assign cellOpenCheckSelect = openCheck; // [RULE1]

  cell_channel_select uChan (
    .clk               (clk),
    .rst_n             (rst_n),
    .openCheck         (openCheck),
    .measureEnable     (cellMeasureEnable),
    .polaritySelect    (cellPolaritySelect),
    .channelMeasure    (cellChannelMeasure),
    .comparatorLowOnly (comparatorLowSideOnly),
    .useOpenThreshold  (openThresholdSetSelect),
    .adcSequenceEnable (adcSequenceEnable)
  );

endmodule
`default_nettype wire

// File: rtl/cell_aux_diag_current_map.vh
/*
 Register map of the cell and auxiliary test current configuration block:
 register indices, field positions, reset values and mode encodings.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CELL_AUX_DIAG_CURRENT_MAP_VH
`define CELL_AUX_DIAG_CURRENT_MAP_VH

// Register indices (word addresses on the register port)
`define CELL_TEST_CURRENT_CONFIG_ADDR 8'h6c
`define AUX_TEST_CURRENT_CONFIG_ADDR  8'h6d

// Reset values
`define CELL_TEST_CURRENT_CONFIG_RST  16'h0000
`define AUX_TEST_CURRENT_CONFIG_RST   16'h0000

// Cell register fields
`define CELL_OPEN_CHECK_SELECT_BIT    15
`define CELL_TEST_EN_MSB              14
`define CELL_TEST_EN_LSB              0
`define CELL_COUNT                    15

// Aux register fields
`define AUX_TEST_EN_MSB               5
`define AUX_TEST_EN_LSB               0
`define AUX_PIN_COUNT                 4
`define SENSE_POS_BIT                 5
`define SENSE_NEG_BIT                 4

// Open-check select encodings
`define OPEN_CHECK_NORMAL             1'b0
`define OPEN_CHECK_DIAG               1'b1

// Test current direction encoding for pull-up
`define DIRECTION_PULL_UP             1'b1

`endif

// File: rtl/cell_channel_select.v
/*
 Per-cell measurement qualifier and threshold selection.
 Assumes the enable and polarity masks are stable register outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cell_aux_diag_current_map.vh"

module cell_channel_select (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        openCheck,
  input  wire [14:0] measureEnable,
  input  wire [14:0] polaritySelect,
  output reg  [14:0] channelMeasure,
  output reg         comparatorLowOnly,
  output reg         useOpenThreshold,
  output reg         adcSequenceEnable
);

  wire [14:0] next_channelMeasure;

  ////////////////////////////////////////////////////////////////////////////
  // Per channel qualifier
  genvar i;
  generate
    for (i = 0; i < `CELL_COUNT; i = i + 1) begin : gChan
      assign next_channelMeasure[i] = (openCheck == `OPEN_CHECK_DIAG) ?
        (measureEnable[i] & ~polaritySelect[i]) :    // [RULE3]
        measureEnable[i];                            // [RULE2]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge clk) begin
    if (!rst_n) begin
      channelMeasure    <= 15'h0000;
      comparatorLowOnly <= 1'b0;
      useOpenThreshold  <= 1'b0;
      adcSequenceEnable <= 1'b1;
    end else begin
      channelMeasure    <= next_channelMeasure;
      comparatorLowOnly <= openCheck;  // [RULE4]
      useOpenThreshold  <= openCheck;  // [RULE4]
      adcSequenceEnable <= ~openCheck; // [RULE2] [RULE4]
    end
  end

endmodule
`default_nettype wire

// File: verif/cell_aux_diag_current_assertions.sv
/* Checker for the cell and aux test current register pair.
   Sees only the top module's ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module cell_aux_diag_current_checker (
  input wire        clk, rst_n, regWrite, regRead, testCurrentDirectionIn,
  input wire        cellOpenCheckSelect, comparatorLowSideOnly, openThresholdSetSelect,
  input wire        adcSequenceEnable, senseSourcePullUp,
  input wire [7:0]  regAddr,
  input wire [15:0] regWriteData, regReadData,
  input wire [14:0] cellMeasureEnable, cellPolaritySelect, cellChannelMeasure, cellSourceOn,
  input wire [9:0]  testCurrentLevelIn, testCurrentLevel,
  input wire [3:0]  auxSourcePullUp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  read_idle_zero_a: assert property (!regRead |=> regReadData == 16'h0000)
    else $error("read data not zero");
  open_sel_a: assert property (regWrite && regAddr == 8'h6c |=>
    cellOpenCheckSelect == $past(regWriteData[15])) else $error("open select");
  cell_src_a: assert property (regWrite && regAddr == 8'h6c |=> ##1
    cellSourceOn == $past(regWriteData[14:0], 2)) else $error("cell sources");
  low_side_a: assert property ($past(rst_n) |-> comparatorLowSideOnly ==
    $past(cellOpenCheckSelect) && openThresholdSetSelect == comparatorLowSideOnly)
    else $error("low side only");
  adc_seq_a: assert property ($past(rst_n) |->
    adcSequenceEnable == !$past(cellOpenCheckSelect)) else $error("adc sequence");
  chan_sel_a: assert property ($past(rst_n) |-> cellChannelMeasure ==
    ($past(cellOpenCheckSelect) ? $past(cellMeasureEnable) & ~$past(cellPolaritySelect)
    : $past(cellMeasureEnable))) else $error("channel select");
  sense_pull_a: assert property (senseSourcePullUp == 1'b1)
    else $error("sense pull-up");
  aux_dir_a: assert property ($past(rst_n) |->
    auxSourcePullUp == {4{$past(testCurrentDirectionIn)}}) else $error("aux direction");
  level_copy_a: assert property ($past(rst_n) |->
    testCurrentLevel == $past(testCurrentLevelIn)) else $error("level copy");
endmodule
bind cell_aux_diag_current_config cell_aux_diag_current_checker chk (.clk(clk), .rst_n(rst_n),
  .regWrite(regWrite), .regRead(regRead), .testCurrentDirectionIn(testCurrentDirectionIn),
  .cellOpenCheckSelect(cellOpenCheckSelect), .comparatorLowSideOnly(comparatorLowSideOnly),
  .openThresholdSetSelect(openThresholdSetSelect), .adcSequenceEnable(adcSequenceEnable),
  .senseSourcePullUp(senseSourcePullUp), .regAddr(regAddr), .regWriteData(regWriteData),
  .regReadData(regReadData), .cellMeasureEnable(cellMeasureEnable),
  .cellPolaritySelect(cellPolaritySelect), .cellChannelMeasure(cellChannelMeasure),
  .cellSourceOn(cellSourceOn), .testCurrentLevelIn(testCurrentLevelIn),
  .testCurrentLevel(testCurrentLevel), .auxSourcePullUp(auxSourcePullUp));
`default_nettype wire

// File: verif/cell_aux_diag_current_config_tb.sv
/* Random and corner tests of the test current register pair.
   Assumes the design with its register port and a bound checker. */
`timescale 1ns/1ps
`default_nettype none
module cell_aux_diag_current_config_tb;
  reg clk = 1'b0, rst_n = 1'b0, regWrite, regRead, auxI2cEnable, testCurrentDirectionIn;
  reg [7:0] regAddr;
  reg [15:0] regWriteData, cv, av;
  reg [14:0] cellMeasureEnable, cellPolaritySelect, me;
  reg [5:0] auxGpioEnable, ae;
  reg [9:0] testCurrentLevelIn;
  wire [15:0] regReadData;
  wire [14:0] cellChannelMeasure, cellSourceOn;
  wire [9:0] testCurrentLevel;
  wire [3:0] auxSourceOn, auxSourcePullUp;
  wire openSel, lowSide, openThr, adcSeq, sensePos, senseNeg, sensePull;
  integer i, seed, n_fail, samples_checked;
  cell_aux_diag_current_config dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .cellMeasureEnable(cellMeasureEnable),
    .cellPolaritySelect(cellPolaritySelect), .auxGpioEnable(auxGpioEnable),
    .auxI2cEnable(auxI2cEnable), .testCurrentLevelIn(testCurrentLevelIn),
    .testCurrentDirectionIn(testCurrentDirectionIn), .cellOpenCheckSelect(openSel),
    .cellChannelMeasure(cellChannelMeasure), .comparatorLowSideOnly(lowSide),
    .openThresholdSetSelect(openThr), .adcSequenceEnable(adcSeq), .cellSourceOn(cellSourceOn),
    .auxSourceOn(auxSourceOn), .sensePosSourceOn(sensePos), .senseNegSourceOn(senseNeg),
    .testCurrentLevel(testCurrentLevel), .auxSourcePullUp(auxSourcePullUp),
    .senseSourcePullUp(sensePull));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Expected source enables after GPIO and I2C gating
  function [5:0] aux_exp(input [5:0] v, input [5:0] g, input c);
    aux_exp = v & ~g & ~{4'h0, c, c};
  endfunction
  function [14:0] meas_exp(input o, input [14:0] e, input [14:0] p);
    meas_exp = o ? e & ~p : e;
  endfunction
  task chk(input [15:0] seen, input [15:0] exp, input string nm);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk); regWrite <= 1'b1; regAddr <= a; regWriteData <= d;
    @(posedge clk); regWrite <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e, input string nm);
    @(posedge clk); regRead <= 1'b1; regAddr <= a;
    @(posedge clk); regRead <= 1'b0;
    #1 chk(regReadData, e, nm);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail = n_fail + 1;
    tally_and_finish;
  end
  // Reset, reset values, then random settings with corners first
  initial begin
    seed = 32'h111b; n_fail = 0; samples_checked = 0; regWrite = 1'b0; regRead = 1'b0;
    regAddr = 8'h00; regWriteData = 16'h0000; cellMeasureEnable = 15'h0000;
    cellPolaritySelect = 15'h0000; auxGpioEnable = 6'h00; auxI2cEnable = 1'b0;
    testCurrentLevelIn = 10'h000; testCurrentDirectionIn = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h6c, 16'h0000, "cell reset");
    rd(8'h6d, 16'h0000, "aux reset");
    chk({adcSeq, sensePull, openSel, lowSide, openThr}, 16'h0018, "reset modes");
    chk({auxSourceOn, sensePos, senseNeg}, 16'h0000, "reset aux");
    chk(cellSourceOn, 16'h0000, "reset cells");
    for (i = 0; i < 48; i = i + 1) begin
      @(posedge clk);
      // Corners: I2C and GPIO masking, open check, then the recommended
      // open check setup with pull-downs on every measured cell
      cellMeasureEnable <= (i == 4) ? 15'h7fff : $random(seed);
      cellPolaritySelect <= $random(seed);
      auxGpioEnable <= (i < 2) ? {6{i[0]}} : $random(seed);
      auxI2cEnable <= (i == 0) ? 1'b1 : $random(seed);
      testCurrentLevelIn <= $random(seed);
      testCurrentDirectionIn <= (i < 2) ? 1'b1 : (i == 4) ? 1'b0 : $random(seed);
      // Aux diagnostic mode (discharge or grounded output) is set elsewhere
      cv = (i == 3) ? 16'h8000 : (i == 4) ? 16'hffff : $random(seed);
      av = (i < 2) ? 16'hffff : $random(seed);
      wr(8'h6c, cv); wr(8'h6d, av); wr(8'h6b - i[7:0], 16'hffff);
      repeat (2) @(posedge clk);
      ae = aux_exp(av[5:0], auxGpioEnable, auxI2cEnable);
      me = meas_exp(cv[15], cellMeasureEnable, cellPolaritySelect);
      #1 chk(cellSourceOn, cv[14:0], "cell sources");
      chk({sensePos, senseNeg, auxSourceOn}, ae, "aux src");
      chk(cellChannelMeasure, me, "measure");
      chk({adcSeq, lowSide}, {~cv[15], cv[15]}, "sequence mode");
      chk({openSel, openThr}, {2{cv[15]}}, "open select");
      chk(testCurrentLevel, testCurrentLevelIn, "level");
      chk(sensePull, 1'b1, "sense pull-up");
      chk(auxSourcePullUp, {4{testCurrentDirectionIn}}, "aux pull-up");
      rd(8'h6c, cv, "cell read");
      rd(8'h6d, av & 16'h003f, "aux read");
      rd(8'h6e + i[7:0], 16'h0000, "unmapped read");
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
